// [hw/bmwd_byte_merge.sv]
// Purpose: Merge write data into a dword under byte enables.
// Assumes: Byte enable bit n covers data bits 8n+7 down to 8n.
// Notes: Purely combinational.
`timescale 1ns/1ps
module bmwd_byte_merge #(
  parameter int BYTES = 4
) (
  // Present contents and write.
  input wire logic [8*BYTES-1:0] old_word,
  input wire logic [8*BYTES-1:0] wdata,
  input wire logic [BYTES-1:0] byte_en,
  // Merged result.
  output logic [8*BYTES-1:0] merged
);

  genvar i;
  generate
    for (i = 0; i < BYTES; i++) begin : g_lane
      assign merged[8*i +: 8] = byte_en[i] ? wdata[8*i +: 8] : old_word[8*i +: 8];
    end
  endgenerate

endmodule

// [hw/bmwd_pkg.sv]
// Purpose: Shared constants and carriers for the bridge memory window decode.
// Assumes: Configuration accesses are dword wide with byte enables.
// Notes: Printed register offsets are byte offsets in configuration space.
package bmwd_pkg;

  // Register byte offsets in configuration space.
  localparam logic [7:0] BMWD_NPF_BASE_OFF = 8'h20;
  localparam logic [7:0] BMWD_NPF_LIMIT_OFF = 8'h22;
  localparam logic [7:0] BMWD_PF_BASE_OFF = 8'h24;
  localparam logic [7:0] BMWD_PF_LIMIT_OFF = 8'h26;
  localparam logic [7:0] BMWD_PF_BASE_UP_OFF = 8'h28;
  localparam logic [7:0] BMWD_PF_LIMIT_UP_OFF = 8'h2c;

  // Field layout of the 16-bit window registers.
  localparam int BMWD_FIELD_LSB = 4;
  localparam int BMWD_FIELD_W = 12;
  localparam int BMWD_HALF_W = 16;
  localparam int BMWD_DECODE_LSB = 20;
  localparam int BMWD_CMP_W = 64 - BMWD_DECODE_LSB;

  // Capability codes in bits 3:0 of the prefetchable base and limit.
  localparam logic [3:0] BMWD_CODE_32 = 4'h0;
  localparam logic [3:0] BMWD_CODE_64 = 4'h1;

  // Values after reset.
  localparam logic [11:0] BMWD_FIELD_RST = 12'h000;
  localparam logic [31:0] BMWD_UPPER_RST = 32'h0000_0000;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] offset;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } bmwd_cfg_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] rdata;
  } bmwd_cfg_rsp_t;

  typedef struct packed {
    logic valid;
    logic [63:0] addr;
  } bmwd_mem_req_t;

  typedef struct packed {
    logic valid;
    logic downstream;
    logic prefetch;
    logic [63:0] addr;
  } bmwd_route_t;

  typedef struct packed {
    logic [11:0] npf_base;
    logic [11:0] npf_limit;
    logic [11:0] pf_base;
    logic [11:0] pf_limit;
    logic [31:0] pf_base_up;
    logic [31:0] pf_limit_up;
    bmwd_cfg_rsp_t rsp;
    bmwd_route_t route;
  } bmwd_state_t;

  localparam bmwd_state_t BMWD_STATE_RST = '{
    npf_base: BMWD_FIELD_RST,
    npf_limit: BMWD_FIELD_RST,
    pf_base: BMWD_FIELD_RST,
    pf_limit: BMWD_FIELD_RST,
    pf_base_up: BMWD_UPPER_RST,
    pf_limit_up: BMWD_UPPER_RST,
    rsp: '0,
    route: '0
  };

endpackage

// [hw/bmwd_range_check.sv]
// Purpose: Inclusive range compare of an address slice against a base and limit.
// Assumes: Base and limit are already aligned to the compare granule.
// Notes: Purely combinational.
`timescale 1ns/1ps
module bmwd_range_check #(
  parameter int W = 44
) (
  // Window bounds.
  input wire logic [W-1:0] base,
  input wire logic [W-1:0] limit,
  // Address slice under test.
  input wire logic [W-1:0] addr,
  // Result.
  output logic in_range
);

  // Both bounds are inclusive; base above limit leaves the window empty.
  assign in_range = (addr >= base) && (addr <= limit);

endmodule

// [hw/bmwd_window_decode.sv]
// Purpose: Memory window registers and decode for a virtual bridge port.
// Assumes: Config and memory requests come from logic on the same clock.
// Notes: Decisions and read answers are registered and stand one cycle.
// Function
// - Limit register bits 15:4 hold read/write limit A[31:20], reset zero.
// - Limit register bits 3:0 read zero; writes to them are ignored.
// - Limit decode treats A[19:0] as FFFFFh.
// - Forward memory request when prefetch base <= A[31:20] <= prefetch limit.
// - Prefetch base bits 15:4 hold read/write base A[31:20], reset zero.
// - Prefetch base decode treats A[19:0] as zero.
// - Prefetch limit decode treats A[19:0] as all ones.
// - Prefetch limit bits 15:4 hold read/write limit A[31:20], reset zero.
// - Prefetch base and limit bits 3:0 return the same read-only width code.
// - Width code reads 1h after reset, meaning 64-bit support.
// - With 32-bit code, both upper prefetch words read zero.
// - With 64-bit code, both upper prefetch words are read/write.
// - Upper base word is read/write A[63:32] of prefetch base, reset zero.
// - Upper limit word is read/write A[63:32] of prefetch limit, reset zero.
// - Non-prefetch base bits 15:4 give A[31:20]; low decode bits zero.
// - Route accesses inside non-prefetch base..limit inclusive downstream.
`timescale 1ns/1ps
module bmwd_window_decode
  import bmwd_pkg::*;
#(
  parameter logic [3:0] WIDTH_CODE = BMWD_CODE_64
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Configuration access.
  input wire bmwd_cfg_req_t cfg,
  output bmwd_cfg_rsp_t cfg_rsp,
  // Processor memory requests.
  input wire bmwd_mem_req_t mem,
  // Routing decision.
  output bmwd_route_t route
);

  bmwd_state_t st;
  bmwd_state_t next_st;
  logic [31:0] read_word;
  logic [31:0] merged;
  logic is_64;
  logic npf_hit;
  logic pf_hit;
  logic [BMWD_CMP_W-1:0] npf_lo;
  logic [BMWD_CMP_W-1:0] npf_hi;
  logic [BMWD_CMP_W-1:0] pf_lo;
  logic [BMWD_CMP_W-1:0] pf_hi;

  assign is_64 = (WIDTH_CODE == BMWD_CODE_64);

  // Read view of the addressed dword; in the 20h and 24h dwords the low nibbles of each half are constants.
  always_comb begin
    read_word = 32'h0000_0000;
    unique case (cfg.offset[7:2])
      BMWD_NPF_BASE_OFF[7:2]: begin
        read_word = {st.npf_limit, 4'h0, st.npf_base, 4'h0};
      end
      BMWD_PF_BASE_OFF[7:2]: begin
        read_word = {st.pf_limit, WIDTH_CODE, st.pf_base, WIDTH_CODE};
      end
      BMWD_PF_BASE_UP_OFF[7:2]: begin
        read_word = is_64 ? st.pf_base_up : 32'h0000_0000;
      end
      BMWD_PF_LIMIT_UP_OFF[7:2]: begin
        read_word = is_64 ? st.pf_limit_up : 32'h0000_0000;
      end
      default: begin
        read_word = 32'h0000_0000;
      end
    endcase
  end

  bmwd_byte_merge #(
    .BYTES(4)
  ) u_merge (
    .old_word(read_word),
    .wdata(cfg.wdata),
    .byte_en(cfg.byte_en),
    .merged(merged)
  );

  // non-prefetch bounds above 4 GB are zero
  assign npf_lo = {32'h0000_0000, st.npf_base};
  // limit low bits implied all ones
  assign npf_hi = {32'h0000_0000, st.npf_limit};
  assign pf_lo = {st.pf_base_up, st.pf_base};
  // limit granule includes its top byte
  assign pf_hi = {st.pf_limit_up, st.pf_limit};

  // Comparing A[63:20] against the bounds makes the base granule start at
  // zero and the limit granule end at all ones without widening the compare.
  bmwd_range_check #(
    .W(BMWD_CMP_W)
  ) u_npf_range (
    .base(npf_lo),
    .limit(npf_hi),
    .addr(mem.addr[63:BMWD_DECODE_LSB]),
    .in_range(npf_hit)
  );

  // base granule aligned to 1 MB
  bmwd_range_check #(
    .W(BMWD_CMP_W)
  ) u_pf_range (
    .base(pf_lo),
    .limit(pf_hi),
    .addr(mem.addr[63:BMWD_DECODE_LSB]),
    .in_range(pf_hit)
  );

  always_comb begin
    next_st = st;
    next_st.rsp.valid = 1'b0;
    next_st.rsp.rdata = 32'h0000_0000;
    if (cfg.wr) begin
      unique case (cfg.offset[7:2])
        BMWD_NPF_BASE_OFF[7:2]: begin
          next_st.npf_base = merged[BMWD_FIELD_LSB +: BMWD_FIELD_W];
          next_st.npf_limit = merged[BMWD_HALF_W + BMWD_FIELD_LSB +: BMWD_FIELD_W];
        end
        BMWD_PF_BASE_OFF[7:2]: begin
          next_st.pf_base = merged[BMWD_FIELD_LSB +: BMWD_FIELD_W];
          next_st.pf_limit = merged[BMWD_HALF_W + BMWD_FIELD_LSB +: BMWD_FIELD_W];
        end
        BMWD_PF_BASE_UP_OFF[7:2]: begin
          if (is_64) begin
            next_st.pf_base_up = merged;
          end
        end
        BMWD_PF_LIMIT_UP_OFF[7:2]: begin
          if (is_64) begin
            next_st.pf_limit_up = merged;
          end
        end
        default: begin
          next_st.npf_base = st.npf_base;
        end
      endcase
    end
    if (cfg.rd) begin
      // A read beside a write in the same cycle returns the old contents.
      next_st.rsp.valid = 1'b1;
      next_st.rsp.rdata = read_word;
    end
    // Overlapping windows are not arbitrated; a hit in either routes down.
    // non-prefetch and prefetch window routing
    next_st.route.valid = mem.valid;
    next_st.route.downstream = mem.valid && (npf_hit || pf_hit);
    next_st.route.prefetch = mem.valid && pf_hit;
    next_st.route.addr = mem.addr;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st <= BMWD_STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign cfg_rsp = st.rsp;
  assign route = st.route;

  // Checks.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  logic a_npf_in;
  logic a_pf_in;
  assign a_npf_in = (mem.addr[63:32] == 32'h0000_0000)
    && (mem.addr[31:20] >= st.npf_base) && (mem.addr[31:20] <= st.npf_limit);
  assign a_pf_in = ({mem.addr[63:32], mem.addr[31:20]} >= {st.pf_base_up, st.pf_base})
    && ({mem.addr[63:32], mem.addr[31:20]} <= {st.pf_limit_up, st.pf_limit});

  sequence s_read_at(logic [7:0] off);
    cfg.rd && !cfg.wr && (cfg.offset[7:2] == off[7:2]);
  endsequence

  sequence s_full_write_at(logic [7:0] off);
    cfg.wr && (cfg.byte_en == 4'hf) && (cfg.offset[7:2] == off[7:2]);
  endsequence

  // Full writes that the 64-bit code lets reach the upper words.
  sequence s_wide_full_write_at(logic [7:0] off);
    is_64 && cfg.wr && (cfg.byte_en == 4'hf) && (cfg.offset[7:2] == off[7:2]);
  endsequence

  chk_limit_low_zero: assert property (
    s_read_at(BMWD_NPF_LIMIT_OFF) |=> cfg_rsp.valid && (cfg_rsp.rdata[19:16] == 4'h0)
      && (cfg_rsp.rdata[3:0] == 4'h0))
    else $error("limit low nibble not zero");

  chk_width_code_read: assert property (
    s_read_at(BMWD_PF_BASE_OFF) |=> cfg_rsp.valid
      && (cfg_rsp.rdata[3:0] == WIDTH_CODE) && (cfg_rsp.rdata[19:16] == WIDTH_CODE))
    else $error("width code mismatch");

  chk_upper_zero_32: assert property (
    !is_64 ##0 s_read_at(BMWD_PF_BASE_UP_OFF) |=> cfg_rsp.rdata == 32'h0000_0000)
    else $error("upper word not zero in 32-bit mode");

  chk_upper_base_write: assert property (
    s_wide_full_write_at(BMWD_PF_BASE_UP_OFF) |=> st.pf_base_up == $past(cfg.wdata))
    else $error("upper base word not stored");

  chk_limit_write: assert property (
    s_full_write_at(BMWD_NPF_LIMIT_OFF) |=> st.npf_limit == $past(cfg.wdata[31:20]))
    else $error("limit field not stored");

  chk_pf_base_write: assert property (
    s_full_write_at(BMWD_PF_BASE_OFF) |=> (st.pf_base == $past(cfg.wdata[15:4]))
      && (st.pf_limit == $past(cfg.wdata[31:20])))
    else $error("prefetch fields not stored");

  chk_npf_route: assert property (
    mem.valid && a_npf_in |=> route.valid && route.downstream)
    else $error("non-prefetch hit not routed");

  chk_pf_route: assert property (
    mem.valid && a_pf_in |=> route.valid && route.downstream && route.prefetch)
    else $error("prefetch hit not routed");

  chk_miss_kept: assert property (
    mem.valid && !a_npf_in && !a_pf_in |=> route.valid && !route.downstream
      && !route.prefetch && (route.addr == $past(mem.addr)))
    else $error("miss routed downstream");

  chk_rsp_pulse: assert property (
    !cfg.rd |=> !cfg_rsp.valid)
    else $error("response without read");

  chk_upper_limit_write: assert property (
    s_wide_full_write_at(BMWD_PF_LIMIT_UP_OFF) |=> st.pf_limit_up == $past(cfg.wdata))
    else $error("upper limit word not stored");

  // A 32-bit bridge must never let a stray write reach the upper words.
  chk_upper_kept_32: assert property (
    !is_64 |-> (st.pf_base_up == 32'h0000_0000) && (st.pf_limit_up == 32'h0000_0000))
    else $error("upper word stored in 32-bit mode");

  chk_upper_read_64: assert property (
    is_64 ##0 s_read_at(BMWD_PF_LIMIT_UP_OFF) |=> cfg_rsp.valid
      && (cfg_rsp.rdata == $past(st.pf_limit_up)))
    else $error("upper limit word read back wrong");

  chk_npf_base_write: assert property (
    s_full_write_at(BMWD_NPF_BASE_OFF) |=> st.npf_base == $past(cfg.wdata[15:4]))
    else $error("base field not stored");

  chk_npf_read_back: assert property (
    s_read_at(BMWD_NPF_BASE_OFF) |=> (cfg_rsp.rdata[31:20] == $past(st.npf_limit))
      && (cfg_rsp.rdata[15:4] == $past(st.npf_base)))
    else $error("non-prefetch fields read back wrong");

  chk_pf_limit_read: assert property (
    s_read_at(BMWD_PF_LIMIT_OFF) |=> (cfg_rsp.rdata[31:20] == $past(st.pf_limit))
      && (cfg_rsp.rdata[15:4] == $past(st.pf_base)))
    else $error("prefetch fields read back wrong");

  // Writes that leave the upper half disabled must not disturb the limit.
  chk_limit_byte_kept: assert property (
    cfg.wr && (cfg.byte_en[3:2] == 2'b00) && (cfg.offset[7:2] == BMWD_NPF_LIMIT_OFF[7:2])
      |=> st.npf_limit == $past(st.npf_limit))
    else $error("limit changed by a lower-half write");

  // This check must run through reset, so it overrides the default disable.
  chk_reset_state: assert property (
    disable iff (1'b0)
    !rst_n |=> (st.npf_base == BMWD_FIELD_RST) && (st.npf_limit == BMWD_FIELD_RST)
      && (st.pf_base == BMWD_FIELD_RST) && (st.pf_limit == BMWD_FIELD_RST)
      && (st.pf_base_up == BMWD_UPPER_RST) && (st.pf_limit_up == BMWD_UPPER_RST)
      && !cfg_rsp.valid && !route.valid)
    else $error("state not at reset values");

  chk_route_idle: assert property (
    !mem.valid |=> !route.valid && !route.downstream && !route.prefetch)
    else $error("route decided without a request");

  // The address rides along with every decision, hit or miss.
  chk_route_addr: assert property (
    mem.valid |=> route.valid && (route.addr == $past(mem.addr)))
    else $error("routed address differs from request");

endmodule

// [testbench/bmwd_host_model.sv]
// Purpose: Host model issuing configuration and memory requests to the window decode.
// Assumes: Requests change at the falling edge and are taken at the next rising edge.
// Notes: Released requests drop rd, wr and valid; the other fields carry the inverse of their last value.
`timescale 1ns/1ps
module bmwd_host_model
  import bmwd_pkg::*;
(
  // Clock.
  input wire logic clock,
  // Requests.
  output bmwd_cfg_req_t cfg,
  output bmwd_mem_req_t mem,
  // Answers.
  input wire bmwd_cfg_rsp_t rsp,
  input wire bmwd_route_t route
);
  initial begin
    cfg = '0;
    mem = '0;
  end

  // The answer is sampled one falling edge after the taking edge, while it stands.
  task automatic cfg_access(input logic wr, input logic [7:0] off, input logic [3:0] be,
      input logic [31:0] d, output bmwd_cfg_rsp_t got);
    @(negedge clock);
    cfg = '{rd: !wr, wr: wr, offset: off, byte_en: be, wdata: d};
    @(negedge clock);
    got = rsp;
    cfg = '{rd: 1'b0, wr: 1'b0, offset: ~off, byte_en: ~be, wdata: ~d};
  endtask

  task automatic mem_send(input logic [63:0] a, output bmwd_route_t got);
    @(negedge clock);
    mem = '{valid: 1'b1, addr: a};
    @(negedge clock);
    got = route;
    mem = '{valid: 1'b0, addr: ~a};
  endtask
endmodule

// [testbench/bridge_memory_window_decode_tb.sv]
// Purpose: Self-checking bench for the bridge memory window decode.
// Assumes: dut_u has the 64-bit width code; dut32_u beside it has the 32-bit code.
// Notes: Windows are reprogrammed at random and addresses aimed at their edges.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %0t got %h expected %h", $time, g, e); end end
module bridge_memory_window_decode_tb;
  import bmwd_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  int mismatches = 0;
  int compares = 0;
  bmwd_cfg_req_t cfg;
  bmwd_mem_req_t mem;
  bmwd_cfg_rsp_t rsp, rsp32, got;
  bmwd_route_t route, route32, rt;
  logic [11:0] f [4];
  logic [31:0] up [2];
  logic [63:0] a;

  always #5 clock = ~clock;

  bmwd_host_model host_u (.clock(clock), .cfg(cfg), .mem(mem), .rsp(rsp), .route(route));
  bmwd_window_decode dut_u (.clock(clock), .rst_n(rst_n), .cfg(cfg), .cfg_rsp(rsp),
    .mem(mem), .route(route));
  bmwd_window_decode #(.WIDTH_CODE(BMWD_CODE_32)) dut32_u (.clock(clock), .rst_n(rst_n),
    .cfg(cfg), .cfg_rsp(rsp32), .mem(mem), .route(route32));

  function automatic logic in_win(logic [43:0] x, logic [43:0] lo, logic [43:0] hi);
    return (x >= lo) && (x <= hi);
  endfunction

  function automatic logic pf_hit(logic [63:0] x, logic [31:0] bu, logic [31:0] lu);
    return in_win(x[63:20], {bu, f[2]}, {lu, f[3]});
  endfunction

  function automatic logic npf_hit(logic [63:0] x);
    return (x[63:32] == 32'h0) && in_win({32'h0, x[31:20]}, {32'h0, f[0]}, {32'h0, f[1]});
  endfunction

  task automatic rd(input logic [7:0] off, input logic [31:0] e, input logic [31:0] e32);
    host_u.cfg_access(1'b0, off, 4'h0, 32'h0, got);
    `CHK(got.valid, 1'b1)
    `CHK(rsp32.valid, 1'b1)
    `CHK(got.rdata, e)
    `CHK(rsp32.rdata, e32)
  endtask

  task automatic wr(input logic [7:0] off, input logic [3:0] be, input logic [31:0] d);
    host_u.cfg_access(1'b1, off, be, d, got);
  endtask

  task automatic chk_mem(input logic [63:0] x);
    host_u.mem_send(x, rt);
    `CHK(rt.valid, 1'b1)
    `CHK(rt.addr, x)
    `CHK(rt.prefetch, pf_hit(x, up[0], up[1]))
    `CHK(rt.downstream, npf_hit(x) || pf_hit(x, up[0], up[1]))
    `CHK(route32.prefetch, pf_hit(x, 32'h0, 32'h0))
    `CHK(route32.downstream, npf_hit(x) || pf_hit(x, 32'h0, 32'h0))
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(37));
    f = '{default: 12'h0};
    up = '{default: 32'h0};
    repeat (20) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    @(posedge clock);
    rd(8'h20, 32'h0, 32'h0);
    rd(8'h24, 32'h0001_0001, 32'h0);
    rd(8'h28, 32'h0, 32'h0);
    rd(8'h2c, 32'h0, 32'h0);
    rd(8'h30, 32'h0, 32'h0);
    chk_mem(64'h0000_0000_000f_ffff);
    chk_mem(64'h0000_0000_0010_0000);
    wr(8'h20, 4'hf, 32'hffff_ffff);
    wr(8'h24, 4'hf, 32'hffff_ffff);
    rd(8'h20, 32'hfff0_fff0, 32'hfff0_fff0);
    rd(8'h24, 32'hfff1_fff1, 32'hfff0_fff0);
    wr(BMWD_NPF_LIMIT_OFF, 4'hc, 32'h1230_abcd);
    rd(8'h20, 32'h1230_fff0, 32'h1230_fff0);
    // A lower-half write must leave the limit field alone.
    wr(8'h20, 4'h3, 32'h5555_5555);
    rd(8'h20, 32'h1230_5550, 32'h1230_5550);
    wr(8'h28, 4'hf, 32'hdead_beef);
    rd(8'h28, 32'hdead_beef, 32'h0);
    // window programming
    // Upper words stay tiny so hits are common; a hit in either window goes downstream.
    repeat (12) begin
      foreach (f[i]) f[i] = 12'($urandom);
      foreach (up[i]) up[i] = 32'($urandom % 3);
      wr(8'h20, 4'hf, {f[1], 4'h0, f[0], 4'h0});
      wr(8'h24, 4'hf, {f[3], 4'h0, f[2], 4'h0});
      wr(8'h28, 4'hf, up[0]);
      wr(8'h2c, 4'hf, up[1]);
      rd(8'h2c, up[1], 32'h0);
      repeat (16) begin
        a = {32'($urandom % 3), f[$urandom % 4] + 12'($urandom % 3) - 12'h1,
          ($urandom % 2) ? 20'hfffff : 20'h0};
        chk_mem(a);
      end
    end
    // a reset in mid-run brings the defaults back.
    @(negedge clock);
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    f = '{default: 12'h0};
    up = '{default: 32'h0};
    rd(8'h24, 32'h0001_0001, 32'h0);
    rd(8'h2c, 32'h0, 32'h0);
    chk_mem(64'h0000_0000_000f_ffff);
    conclude();
  end

  // The tests need well under ten thousand cycles; this limit only cuts a hang short.
  initial begin
    #100000;
    mismatches++;
    conclude();
  end
endmodule
